/* irq_ctrl.sv */
//Function
// - With the counter array, seven sources, each on one of four levels.
// - Without it, six sources; counter-array source and its enable absent.
// - Level = {high bit, low bit}: 00 lowest up to 11 highest.
// - Vector a request only if no equal or higher level is in service.
// - Request blocked by equal or higher service waits, then is retried.
// - Higher level preempts; interrupted lower service resumes afterwards.
// - Same-level ties go by polling order ext0,t0,ext1,t1,array,serial,t2.
// - Fixed vectors 03,0B,13,1B,33,23,2B for those sources.
// - Vectoring clears edge external flags and timer 0/1 overflow flags only.
// - Global enable bit 7 clear blocks everything; set defers to each bit.
// - Enable bits 6..0: array,t2,serial,t1,ext1,t0,ext0; 1 enables.
// - High-priority register at B7H pairs bitwise with low-priority register.
`timescale 1ns/1ns
module irq_ctrl
  import irq_pkg::*;
#(
  parameter bit HAS_COUNTER_ARRAY = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Special-function register port of the core
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Request flags from the peripherals
  input wire logic ext0_flag,
  input wire logic ext0_edge_mode,
  input wire logic timer0_overflow_flag,
  input wire logic ext1_flag,
  input wire logic ext1_edge_mode,
  input wire logic timer1_overflow_flag,
  input wire logic counter_array_overflow_flag,
  input wire logic [4:0] module_match_flags,
  input wire logic rx_done_flag,
  input wire logic tx_done_flag,
  input wire logic timer2_overflow_flag,
  input wire logic timer2_external_flag,
  // Hardware clears back to the peripherals
  output logic ext0_flag_clr,
  output logic timer0_flag_clr,
  output logic ext1_flag_clr,
  output logic timer1_flag_clr,
  // Core handshake
  output logic irq_req,
  output logic [7:0] irq_vector,
  input wire logic vector_ack,
  input wire logic reti_done,
  output logic [NUM_LEVELS-1:0] in_service_levels
);

  typedef struct packed {
    ctrl_state_e state;
    logic irq_req;
    logic [7:0] vector;
    src_t src;
    level_t level;
    logic [3:0] clr;
    logic [7:0] enable;
    logic [7:0] prio_low;
    logic [7:0] prio_high;
    logic [7:0] rdata;
  } ctrl_s;

  localparam logic [7:0] ENABLE_MASK = HAS_COUNTER_ARRAY ? ENABLE_MASK_FULL : ENABLE_MASK_NOCA;
  localparam logic [7:0] PRIO_MASK = HAS_COUNTER_ARRAY ? PRIO_MASK_FULL : PRIO_MASK_NOCA;

  ctrl_s r_reg;
  ctrl_s r_next;

  logic [NUM_SRC-1:0] raw;
  logic [NUM_SRC-1:0] pending;
  logic found;
  src_t win_src;
  level_t win_level;
  logic eligible;
  logic take;
  logic [NUM_LEVELS-1:0] stk_in_service;
  logic stk_any;
  level_t stk_top;

  // Each source is raised by any of its own flags
  assign raw = {timer2_overflow_flag | timer2_external_flag,
                rx_done_flag | tx_done_flag,
                (counter_array_overflow_flag | (|module_match_flags)) & HAS_COUNTER_ARRAY,
                timer1_overflow_flag,
                ext1_flag,
                timer0_overflow_flag,
                ext0_flag};

  genvar gs;
  generate
    for (gs = 0; gs < NUM_SRC; gs++) begin : g_gate
      assign pending[gs] = raw[gs] & r_reg.enable[BIT_GLOBAL]
                           & r_reg.enable[src_bit(src_t'(gs))];
    end
  endgenerate

  irq_resolver u_resolver (
    .pending(pending),
    .prio_low(r_reg.prio_low),
    .prio_high(r_reg.prio_high),
    .found(found),
    .win_src(win_src),
    .win_level(win_level)
  );

  // Only a strictly higher level than the deepest service may enter
  assign eligible = found && (!stk_any || win_level > stk_top);
  assign take = (r_reg.state == ST_REQ) && vector_ack;

  isr_level_stack u_stack (
    .clk(clk),
    .rst_b(rst_b),
    .push(take),
    .push_level(r_reg.level),
    .pop(reti_done),
    .in_service(stk_in_service),
    .any(stk_any),
    .top(stk_top)
  );

  always_comb begin
    r_next = r_reg;
    r_next.clr = '0;

    unique case (r_reg.state)
      ST_IDLE: begin
        if (eligible) begin
          r_next.state = ST_REQ;
          r_next.irq_req = 1'b1;
          r_next.src = win_src;
          r_next.level = win_level;
          r_next.vector = src_vector(win_src);
        end
      end
      ST_REQ: begin
        if (vector_ack) begin
          r_next.state = ST_IDLE;
          r_next.irq_req = 1'b0;
          // Level-activated and shared flags stay for software
          r_next.clr[0] = (r_reg.src == SRC_EXT0) && ext0_edge_mode;
          r_next.clr[1] = (r_reg.src == SRC_T0);
          r_next.clr[2] = (r_reg.src == SRC_EXT1) && ext1_edge_mode;
          r_next.clr[3] = (r_reg.src == SRC_T1);
        end else if (eligible) begin
          // A later, higher request may replace the offered one
          r_next.src = win_src;
          r_next.level = win_level;
          r_next.vector = src_vector(win_src);
        end else begin
          // Request withdrawn or masked before the core took it
          r_next.state = ST_IDLE;
          r_next.irq_req = 1'b0;
        end
      end
    endcase

    if (sfr_wr) begin
      unique case (sfr_addr)
        ADDR_ENABLE: r_next.enable = sfr_wdata & ENABLE_MASK;
        ADDR_PRIO_HIGH: r_next.prio_high = sfr_wdata & PRIO_MASK;
        ADDR_PRIO_LOW: r_next.prio_low = sfr_wdata & PRIO_MASK;
        default: ;
      endcase
    end

    unique case (sfr_addr)
      ADDR_ENABLE: r_next.rdata = r_reg.enable;
      ADDR_PRIO_HIGH: r_next.rdata = r_reg.prio_high;
      ADDR_PRIO_LOW: r_next.rdata = r_reg.prio_low;
      default: r_next.rdata = READ_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_reg.state <= ST_IDLE;
      r_reg.irq_req <= 1'b0;
      r_reg.vector <= '0;
      r_reg.src <= SRC_EXT0;
      r_reg.level <= '0;
      r_reg.clr <= '0;
      r_reg.enable <= ENABLE_RESET;
      r_reg.prio_low <= PRIO_RESET;
      r_reg.prio_high <= PRIO_RESET;
      r_reg.rdata <= READ_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sfr_rdata = r_reg.rdata;
  assign irq_req = r_reg.irq_req;
  assign irq_vector = r_reg.vector;
  assign ext0_flag_clr = r_reg.clr[0];
  assign timer0_flag_clr = r_reg.clr[1];
  assign ext1_flag_clr = r_reg.clr[2];
  assign timer1_flag_clr = r_reg.clr[3];
  assign in_service_levels = stk_in_service;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  chk_vector_fixed: assert property (
    irq_req |-> irq_vector == src_vector(r_reg.src))
    else $error("vector does not match offered source");

  chk_global_gate: assert property (
    $rose(irq_req) |-> $past(r_reg.enable[BIT_GLOBAL]))
    else $error("request raised with global enable clear");

  chk_nest_rule: assert property (
    $rose(irq_req) |-> $past(!stk_any) || r_reg.level > $past(stk_top))
    else $error("request raised at or below level in service");

  chk_equal_wait: assert property (
    (r_reg.state == ST_IDLE && stk_any && found && win_level <= stk_top) |=> !irq_req)
    else $error("blocked request was offered");

  chk_timer_clear: assert property (
    (take && r_reg.src == SRC_T0) |=> timer0_flag_clr ##1 !timer0_flag_clr)
    else $error("timer 0 flag not cleared for one cycle");

  chk_soft_clear: assert property (
    (take && (r_reg.src == SRC_SERIAL || r_reg.src == SRC_T2 || r_reg.src == SRC_CA))
    |=> !(ext0_flag_clr || timer0_flag_clr || ext1_flag_clr || timer1_flag_clr))
    else $error("hardware cleared a software-owned flag");

  chk_push_level: assert property (
    take |=> in_service_levels[$past(r_reg.level)] && !irq_req)
    else $error("accepted level not marked in service");

  chk_return_pop: assert property (
    (reti_done && !take && stk_any)
    |=> $countones(in_service_levels) == $countones($past(in_service_levels)) - 1)
    else $error("return did not release one level");

  chk_no_array: assert property (
    !HAS_COUNTER_ARRAY |-> !r_reg.enable[BIT_CA] && !raw[SRC_CA])
    else $error("counter array source present on reduced variant");

  chk_quiet_off: assert property (
    (!r_reg.enable[BIT_GLOBAL] && !irq_req) |=> !irq_req)
    else $error("request raised while disabled");

  // Levels of all gated requests, formed apart from the resolver's function
  logic [NUM_LEVELS-1:0] pend_levels;
  always_comb begin
    logic [2:0] b;
    b = '0;
    pend_levels = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      b = src_bit(src_t'(s));
      if (pending[s]) begin
        pend_levels[{r_reg.prio_high[b], r_reg.prio_low[b]}] = 1'b1;
      end
    end
  end

  chk_highest_wins: assert property (
    $rose(irq_req) |-> ($past(pend_levels) >> r_reg.level) == 4'h1)
    else $error("offered level is not the highest pending level");

  chk_own_enable: assert property (
    $rose(irq_req) |-> (($past(r_reg.enable) >> src_bit(r_reg.src)) & 8'h01) == 8'h01)
    else $error("request raised for a source whose enable is clear");

  chk_ext0_clear: assert property (
    (take && r_reg.src == SRC_EXT0) |=> ext0_flag_clr == $past(ext0_edge_mode))
    else $error("external 0 clear does not follow its trigger mode");

  chk_ext1_clear: assert property (
    (take && r_reg.src == SRC_EXT1) |=> ext1_flag_clr == $past(ext1_edge_mode))
    else $error("external 1 clear does not follow its trigger mode");

  chk_clear_idle: assert property (
    !take |=> !(ext0_flag_clr || timer0_flag_clr || ext1_flag_clr || timer1_flag_clr))
    else $error("flag clear pulsed without a taken vector");

  chk_read_lag: assert property (
    sfr_addr == ADDR_PRIO_HIGH |=> sfr_rdata == $past(r_reg.prio_high))
    else $error("high priority register read back wrong");

  chk_withdraw_offer: assert property (
    (r_reg.state == ST_REQ && !vector_ack && !eligible) |=> !irq_req)
    else $error("offer kept after its request was withdrawn");

  cov_preempt: cover property (
    $rose(irq_req) && stk_any);
  cov_tie_break: cover property (
    $rose(irq_req) && $past(pending[SRC_EXT0] && pending[SRC_T0]));
  cov_nested_return: cover property (
    reti_done && $countones(in_service_levels) > 1);
  cov_replace: cover property (
    r_reg.state == ST_REQ && !vector_ack && eligible && win_src != r_reg.src);
  cov_withdraw: cover property (
    r_reg.state == ST_REQ && !vector_ack && !eligible);

endmodule : irq_ctrl

/* irq_pkg.sv */
package irq_pkg;

  localparam int NUM_SRC = 7;
  localparam int NUM_LEVELS = 4;

  typedef logic [2:0] src_t;
  typedef logic [1:0] level_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_REQ  = 2'b10
  } ctrl_state_e;

  // Register addresses on the core's special-function bus
  localparam logic [7:0] ADDR_ENABLE = 8'hA8;
  localparam logic [7:0] ADDR_PRIO_HIGH = 8'hB7;
  localparam logic [7:0] ADDR_PRIO_LOW = 8'hB8;

  localparam int BIT_GLOBAL = 7;
  localparam int BIT_CA = 6;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] PRIO_RESET = 8'h00;
  localparam logic [7:0] ENABLE_MASK_FULL = 8'hFF;
  localparam logic [7:0] ENABLE_MASK_NOCA = 8'hBF;
  localparam logic [7:0] PRIO_MASK_FULL = 8'h7F;
  localparam logic [7:0] PRIO_MASK_NOCA = 8'h3F;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Sources numbered in polling order
  localparam src_t SRC_EXT0 = 3'h0;
  localparam src_t SRC_T0 = 3'h1;
  localparam src_t SRC_EXT1 = 3'h2;
  localparam src_t SRC_T1 = 3'h3;
  localparam src_t SRC_CA = 3'h4;
  localparam src_t SRC_SERIAL = 3'h5;
  localparam src_t SRC_T2 = 3'h6;

  localparam logic [7:0] VEC_EXT0 = 8'h03;
  localparam logic [7:0] VEC_T0 = 8'h0B;
  localparam logic [7:0] VEC_EXT1 = 8'h13;
  localparam logic [7:0] VEC_T1 = 8'h1B;
  localparam logic [7:0] VEC_CA = 8'h33;
  localparam logic [7:0] VEC_SERIAL = 8'h23;
  localparam logic [7:0] VEC_T2 = 8'h2B;

  // Bit position of a source in the enable and priority registers
  function automatic logic [2:0] src_bit(src_t s);
    unique case (s)
      SRC_EXT0: return 3'h0;
      SRC_T0: return 3'h1;
      SRC_EXT1: return 3'h2;
      SRC_T1: return 3'h3;
      SRC_CA: return 3'h6;
      SRC_SERIAL: return 3'h4;
      default: return 3'h5;
    endcase
  endfunction : src_bit

  function automatic logic [7:0] src_vector(src_t s);
    unique case (s)
      SRC_EXT0: return VEC_EXT0;
      SRC_T0: return VEC_T0;
      SRC_EXT1: return VEC_EXT1;
      SRC_T1: return VEC_T1;
      SRC_CA: return VEC_CA;
      SRC_SERIAL: return VEC_SERIAL;
      default: return VEC_T2;
    endcase
  endfunction : src_vector

  function automatic level_t level_of(src_t s, logic [7:0] lo, logic [7:0] hi);
    logic [2:0] b;
    b = src_bit(s);
    return {hi[b], lo[b]};
  endfunction : level_of

endpackage : irq_pkg

/* irq_resolver.sv */
`timescale 1ns/1ns
module irq_resolver
  import irq_pkg::*;
(
  // Requests and priority bits
  input wire logic [NUM_SRC-1:0] pending,
  input wire logic [7:0] prio_low,
  input wire logic [7:0] prio_high,
  // Winner
  output logic found,
  output src_t win_src,
  output level_t win_level
);

  always_comb begin
    level_t lv;
    lv = '0;
    found = 1'b0;
    win_src = SRC_EXT0;
    win_level = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      lv = level_of(src_t'(s), prio_low, prio_high);
      // Strictly greater keeps the earlier source on a tie
      if (pending[s] && (!found || lv > win_level)) begin
        found = 1'b1;
        win_src = src_t'(s);
        win_level = lv;
      end
    end
  end

endmodule : irq_resolver

/* isr_level_stack.sv */
`timescale 1ns/1ns
module isr_level_stack
  import irq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Service entry and return
  input wire logic push,
  input wire level_t push_level,
  input wire logic pop,
  // Service state
  output logic [NUM_LEVELS-1:0] in_service,
  output logic any,
  output level_t top
);

  typedef struct packed {
    logic [NUM_LEVELS-1:0] active;
  } stack_s;

  stack_s r_reg;
  stack_s r_next;

  always_comb begin
    r_next = r_reg;
    // Return ends the deepest nested service, the highest level
    if (pop) begin
      for (int l = NUM_LEVELS - 1; l >= 0; l--) begin
        if (r_reg.active[l] && (r_reg.active >> (l + 1)) == '0) begin
          r_next.active[l] = 1'b0;
        end
      end
    end
    if (push) begin
      r_next.active[push_level] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  always_comb begin
    top = '0;
    for (int l = 0; l < NUM_LEVELS; l++) begin
      if (r_reg.active[l]) begin
        top = level_t'(l);
      end
    end
  end

  assign in_service = r_reg.active;
  assign any = |r_reg.active;

endmodule : isr_level_stack

/* core_model.sv */
`timescale 1ns/1ns
module core_model
  import irq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Offer from the controller
  input wire logic irq_req,
  input wire logic [7:0] irq_vector,
  input wire logic stall,
  // Core answers
  output logic vector_ack,
  output logic reti_done
);
  logic [7:0] last_vector;
  int acks;

  // One-cycle ack so the offer falls before a second ack could land; stall models a slow core
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vector_ack <= 1'b0;
      acks <= 0;
      last_vector <= '0;
    end else begin
      vector_ack <= irq_req && !vector_ack && !stall;
      if (vector_ack && irq_req) begin
        last_vector <= irq_vector;
        acks <= acks + 1;
      end
    end
  end

  initial reti_done = 1'b0;

  task automatic ret();
    @(posedge clk);
    reti_done <= 1'b1;
    @(posedge clk);
    reti_done <= 1'b0;
  endtask : ret
endmodule : core_model

/* four_level_interrupt_ctrl_bench.sv */
`timescale 1ns/1ns
module four_level_interrupt_ctrl_bench
  import irq_pkg::*;
;
  logic clk, rst_b, sfr_wr, stall, irq_req, vector_ack, reti_done;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, irq_vector, d, six_rdata, d2;
  logic tx, t2x, six_irq_req;
  logic [1:0] edge_mode;
  logic [4:0] match;
  logic [6:0] req;
  logic [3:0] in_service_levels, clr;
  int mismatches = 0;
  int checked = 0;
  // Sources in polling order
  logic [7:0] vecs [7] = '{VEC_EXT0, VEC_T0, VEC_EXT1, VEC_T1, VEC_CA, VEC_SERIAL, VEC_T2};
  // External 0 is edge mode, external 1 level mode
  logic [3:0] clrs [7] = '{4'h8, 4'h4, 4'h0, 4'h1, 4'h0, 4'h0, 4'h0};

  irq_ctrl u_dut (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ext0_flag(req[0]),
    .ext0_edge_mode(edge_mode[0]), .timer0_overflow_flag(req[1]), .ext1_flag(req[2]),
    .ext1_edge_mode(edge_mode[1]), .timer1_overflow_flag(req[3]),
    .counter_array_overflow_flag(req[4]), .module_match_flags(match),
    .rx_done_flag(req[5]), .tx_done_flag(tx),
    .timer2_overflow_flag(req[6]), .timer2_external_flag(t2x), .ext0_flag_clr(clr[3]),
    .timer0_flag_clr(clr[2]), .ext1_flag_clr(clr[1]), .timer1_flag_clr(clr[0]),
    .irq_req(irq_req), .irq_vector(irq_vector), .vector_ack(vector_ack),
    .reti_done(reti_done), .in_service_levels(in_service_levels));

  core_model u_core (.clk(clk), .rst_b(rst_b), .irq_req(irq_req), .irq_vector(irq_vector),
    .stall(stall), .vector_ack(vector_ack), .reti_done(reti_done));

  // Six-source variant shares bus and flags; no core answers it
  irq_ctrl #(.HAS_COUNTER_ARRAY(1'b0)) u_dut_six (.clk(clk), .rst_b(rst_b),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(six_rdata),
    .ext0_flag(req[0]), .ext0_edge_mode(edge_mode[0]), .timer0_overflow_flag(req[1]),
    .ext1_flag(req[2]), .ext1_edge_mode(edge_mode[1]), .timer1_overflow_flag(req[3]),
    .counter_array_overflow_flag(req[4]), .module_match_flags(match),
    .rx_done_flag(req[5]), .tx_done_flag(tx), .timer2_overflow_flag(req[6]),
    .timer2_external_flag(t2x), .ext0_flag_clr(), .timer0_flag_clr(), .ext1_flag_clr(),
    .timer1_flag_clr(), .irq_req(six_irq_req), .irq_vector(), .vector_ack(1'b0),
    .reti_done(1'b0), .in_service_levels());

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wr <= 1'b1;
    sfr_wdata <= v;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a);
    @(posedge clk);
    sfr_addr <= a;
    @(posedge clk);
    @(negedge clk);
    d = sfr_rdata;
    d2 = six_rdata;
  endtask : rd

  task automatic cfg(logic [7:0] en, logic [7:0] lo, logic [7:0] hi);
    wr(ADDR_ENABLE, en);
    wr(ADDR_PRIO_LOW, lo);
    wr(ADDR_PRIO_HIGH, hi);
  endtask : cfg

  task automatic setf(int i, logic v);
    @(posedge clk);
    req[i] <= v;
  endtask : setf

  // Bounded wait for the core to take an offer, then judge vector and flag clears
  task automatic take(logic [7:0] vec, logic [3:0] c);
    int n;
    n = u_core.acks;
    for (int i = 0; i < 20 && u_core.acks == n; i++) @(negedge clk);
    if (u_core.acks == n) begin
      chk("vector_ack", 8'h00, 8'h01);
      end_of_test();
    end else begin
      chk("irq_vector", u_core.last_vector, vec);
      chk("flag_clr", {4'h0, clr}, {4'h0, c});
    end
  endtask : take

  task automatic t_regs();
    rd(ADDR_ENABLE);
    chk("enable", d, ENABLE_RESET);
    rd(ADDR_PRIO_LOW);
    chk("prio_low", d, PRIO_RESET);
    wr(ADDR_PRIO_HIGH, 8'hFF);
    rd(ADDR_PRIO_HIGH);
    chk("prio_high", d, PRIO_MASK_FULL);
    wr(ADDR_PRIO_HIGH, 8'h00);
    wr(8'hA9, 8'hFF);
    rd(8'hA9);
    chk("unmapped", d, READ_IDLE);
    chk("irq_req", {7'h0, irq_req}, 8'h00);
    chk("in_service", {4'h0, in_service_levels}, 8'h00);
    $display("test regs done");
  endtask : t_regs

  task automatic t_enable();
    cfg(8'h02, 8'h00, 8'h00);
    setf(1, 1'b1);
    repeat (6) @(negedge clk);
    chk("irq_req", {7'h0, irq_req}, 8'h00);
    wr(ADDR_ENABLE, 8'h82);
    take(VEC_T0, 4'h4);
    chk("in_service", {4'h0, in_service_levels}, 8'h01);
    setf(1, 1'b0);
    u_core.ret();
    @(negedge clk);
    chk("in_service", {4'h0, in_service_levels}, 8'h00);
    $display("test enable done");
  endtask : t_enable

  // All seven raised at once on one level: served strictly one after another
  task automatic t_poll();
    cfg(8'hFF, 8'h00, 8'h00);
    @(posedge clk);
    req <= 7'h7F;
    for (int i = 0; i < 7; i++) begin
      take(vecs[i], clrs[i]);
      chk("in_service", {4'h0, in_service_levels}, 8'h01);
      setf(i, 1'b0);
      u_core.ret();
    end
    @(negedge clk);
    chk("in_service", {4'h0, in_service_levels}, 8'h00);
    $display("test poll done");
  endtask : t_poll

  task automatic t_nest();
    cfg(8'hB1, 8'h30, 8'h01);
    setf(6, 1'b1);
    take(VEC_T2, 4'h0);
    chk("in_service", {4'h0, in_service_levels}, 8'h02);
    setf(5, 1'b1);
    repeat (6) @(negedge clk);
    chk("irq_req", {7'h0, irq_req}, 8'h00);
    @(posedge clk);
    stall <= 1'b1;
    req[0] <= 1'b1;
    repeat (5) @(negedge clk);
    chk("irq_req", {7'h0, irq_req}, 8'h01);
    chk("irq_vector", irq_vector, VEC_EXT0);
    @(posedge clk);
    stall <= 1'b0;
    take(VEC_EXT0, 4'h8);
    chk("in_service", {4'h0, in_service_levels}, 8'h06);
    setf(0, 1'b0);
    u_core.ret();
    @(negedge clk);
    chk("in_service", {4'h0, in_service_levels}, 8'h02);
    setf(6, 1'b0);
    u_core.ret();
    take(VEC_SERIAL, 4'h0);
    setf(5, 1'b0);
    u_core.ret();
    $display("test nest done");
  endtask : t_nest

  task automatic t_six();
    cfg(8'hFF, 8'hFF, 8'hFF);
    rd(ADDR_ENABLE);
    chk("enable", d, ENABLE_MASK_FULL);
    chk("six_enable", d2, ENABLE_MASK_NOCA);
    rd(ADDR_PRIO_LOW);
    chk("prio_low", d, PRIO_MASK_FULL);
    chk("six_prio_low", d2, PRIO_MASK_NOCA);
    setf(4, 1'b1);
    take(VEC_CA, 4'h0);
    chk("six_irq_req", {7'h0, six_irq_req}, 8'h00);
    setf(4, 1'b0);
    u_core.ret();
    $display("test six done");
  endtask : t_six

  // Second flag of each shared source, external inputs in the opposite trigger modes
  task automatic t_alt();
    cfg(8'hFF, 8'h00, 8'h00);
    @(posedge clk);
    edge_mode <= 2'b10;
    req[0] <= 1'b1;
    req[2] <= 1'b1;
    match <= 5'h10;
    tx <= 1'b1;
    t2x <= 1'b1;
    take(VEC_EXT0, 4'h0);
    setf(0, 1'b0);
    u_core.ret();
    take(VEC_EXT1, 4'h2);
    setf(2, 1'b0);
    u_core.ret();
    take(VEC_CA, 4'h0);
    @(posedge clk);
    match <= 5'h00;
    u_core.ret();
    take(VEC_SERIAL, 4'h0);
    @(posedge clk);
    tx <= 1'b0;
    u_core.ret();
    take(VEC_T2, 4'h0);
    chk("in_service", {4'h0, in_service_levels}, 8'h01);
    // Reset in mid-service must drop the level and the settings
    @(posedge clk);
    rst_b <= 1'b0;
    t2x <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_ENABLE);
    chk("enable", d, ENABLE_RESET);
    chk("in_service", {4'h0, in_service_levels}, 8'h00);
    chk("irq_req", {7'h0, irq_req}, 8'h00);
    $display("test alt done");
  endtask : t_alt

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    rst_b = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    req = 7'h00;
    stall = 1'b0;
    edge_mode = 2'b01;
    match = 5'h00;
    tx = 1'b0;
    t2x = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_enable();
    t_poll();
    t_six();
    t_nest();
    t_alt();
    end_of_test();
  end
endmodule : four_level_interrupt_ctrl_bench
